/* File: design/acts_pkg.sv */
// Constants shared by the conversion timing select block.
package acts_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_MODE0 = 4'h0;
	localparam logic [3:0] OFF_MODE1 = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h2;
	localparam logic [3:0] OFF_COUNT = 4'h3;
	localparam int BIT_RUN = 7;
	localparam int BIT_CMPEN = 0;
	localparam int FLD_CKSEL_LO = 3;
	localparam int BIT_VMHI = 2;
	localparam int BIT_VMLO = 1;
	localparam int BIT_LOWCUR = 7;
	localparam logic [2:0] CKSEL_DIV32 = 3'h0;
	localparam logic [2:0] CKSEL_DIV16 = 3'h1;
	localparam int DIV32 = 32;
	localparam int DIV16 = 16;
	localparam int START_DELAY_CYC = 1;
	localparam int IRQ_DELAY_CYC = 1;
	localparam int CONV_CYC_NORMAL = 64;
	localparam int CONV_CYC_LOWV = 80;
	localparam int SCAN_CHANNELS = 4;
	localparam int START_TIME_CYC = 1;
	localparam logic [7:0] MODE0_RESET = 8'h00;
	localparam logic [7:0] MODE1_RESET = 8'h00;
	typedef enum logic [2:0] {ACTS_IDLE, ACTS_STARTT, ACTS_DELAY, ACTS_CONV, ACTS_IRQD}
		acts_state_t;
endpackage

/* File: design/acts_timing_select.sv */
// Conversion timing select and no-wait scan sequencer for the A/D converter.
// Behaviour
// - No-wait scans start without stabilization wait.
// - Scan equals delay plus four conversions plus delay.
// - Conversion is 64 normal, 80 low-voltage cycles.
// - One-cycle start delay and interrupt delay.
// - First conversion adds the conversion start time.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module acts_timing_select import acts_pkg::*; (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [ADDR_W-1:0] addr, // Register address.
	input wire logic [7:0] wrData, // Write data.
	input wire logic wrStb, // Write strobe.
	input wire logic rdStb, // Read strobe.
	input wire logic hwTrigger, // Hardware trigger from same-clock logic.
	output logic [7:0] rdData, // Read data, one cycle after rdStb.
	output logic convTick, // One-cycle pulse per conversion clock.
	output logic sampleDone, // Pulse at end of each channel conversion.
	output logic scanIrq // One-cycle completion interrupt pulse.
);
	logic [7:0] modeReg0, modeReg1, next_modeReg0, next_modeReg1;
	logic [7:0] rdNext;
	logic [5:0] divCnt, next_divCnt;
	logic [6:0] cycCnt, next_cycCnt;
	logic [2:0] chanCnt, next_chanCnt;
	logic [15:0] scanCnt, next_scanCnt;
	acts_state_t state, next_state;
	logic convRun, cmpEn, lowVolt, fadTick, lastConvCyc;
	logic [2:0] ckSel;
	logic [5:0] divTop;
	logic [6:0] convTop;

	assign convRun = modeReg0[BIT_RUN];
	assign cmpEn = modeReg0[BIT_CMPEN];
	assign ckSel = modeReg0[FLD_CKSEL_LO +: 3];
	assign lowVolt = modeReg0[BIT_VMHI];
	// Codes other than divide-by-16 fall back to divide-by-32, the slower safe rate.
	assign divTop = (ckSel == CKSEL_DIV16) ? 6'(DIV16 - 1) : 6'(DIV32 - 1);
	assign convTop = lowVolt ? 7'(CONV_CYC_LOWV - 1) : 7'(CONV_CYC_NORMAL - 1);
	assign fadTick = (divCnt == divTop);
	assign lastConvCyc = fadTick && (cycCnt == convTop);

	// Timing bits only take a new value while run and enable are both clear.
	always_comb begin
		next_modeReg0 = modeReg0;
		next_modeReg1 = modeReg1;
		if (wrStb && addr == OFF_MODE0) begin
			if (!convRun && !cmpEn) begin
				next_modeReg0 = wrData;
			end else begin
				next_modeReg0 = {wrData[7:6], modeReg0[5:1], wrData[0]};
			end
		end
		if (wrStb && addr == OFF_MODE1) begin
			next_modeReg1 = wrData;
		end
		if (state == ACTS_IRQD && fadTick && !hwTrigger) begin
			next_modeReg0[BIT_RUN] = 1'b0;
		end
	end

	always_comb begin
		rdNext = 8'h00;
		if (rdStb) begin
			unique case (addr)
				OFF_MODE0: rdNext = modeReg0;
				OFF_MODE1: rdNext = modeReg1;
				OFF_STATUS: rdNext = {5'h00, state};
				OFF_COUNT: rdNext = {5'h00, chanCnt};
				default: rdNext = 8'h00;
			endcase
		end
	end

	always_comb begin
		next_state = state;
		next_divCnt = fadTick ? 6'h00 : divCnt + 6'h01;
		next_cycCnt = cycCnt;
		next_chanCnt = chanCnt;
		next_scanCnt = (state == ACTS_IDLE) ? 16'h0000 : scanCnt + 16'h0001;
		unique case (state)
			ACTS_IDLE: begin
				next_divCnt = 6'h00;
				// No stabilization wait: go straight to the start sequence.
				if (cmpEn && (convRun || hwTrigger)) begin
					next_state = ACTS_STARTT;
					next_chanCnt = 3'h0;
					next_cycCnt = 7'h00;
				end
			end
			ACTS_STARTT: if (fadTick) begin
				next_state = ACTS_DELAY;
			end
			ACTS_DELAY: if (fadTick) begin
				next_state = ACTS_CONV;
				next_cycCnt = 7'h00;
			end
			ACTS_CONV: if (fadTick) begin
				next_cycCnt = cycCnt + 7'h01;
				if (cycCnt == convTop) begin
					next_cycCnt = 7'h00;
					next_chanCnt = chanCnt + 3'h1;
					if (chanCnt == 3'(SCAN_CHANNELS - 1)) begin
						next_state = ACTS_IRQD;
					end
				end
			end
			ACTS_IRQD: if (fadTick) begin
				next_state = ACTS_IDLE;
			end
			default: next_state = ACTS_IDLE;
		endcase
		if (!cmpEn) begin
			next_state = ACTS_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			modeReg0 <= MODE0_RESET;
			modeReg1 <= MODE1_RESET;
			rdData <= 8'h00;
			state <= ACTS_IDLE;
			divCnt <= 6'h00;
			cycCnt <= 7'h00;
			chanCnt <= 3'h0;
			scanCnt <= 16'h0000;
			convTick <= 1'b0;
			sampleDone <= 1'b0;
			scanIrq <= 1'b0;
		end else begin
			modeReg0 <= next_modeReg0;
			modeReg1 <= next_modeReg1;
			rdData <= rdNext;
			state <= next_state;
			divCnt <= next_divCnt;
			cycCnt <= next_cycCnt;
			chanCnt <= next_chanCnt;
			scanCnt <= next_scanCnt;
			convTick <= (state != ACTS_IDLE) && fadTick;
			sampleDone <= (state == ACTS_CONV) && lastConvCyc && cmpEn;
			scanIrq <= (state == ACTS_IRQD) && fadTick && cmpEn;
		end
	end

	// Assertions.
	sequence s_last_conv;
		state == ACTS_CONV && lastConvCyc && chanCnt == 3'(SCAN_CHANNELS - 1);
	endsequence
	sequence s_irq_after(int n);
		##n scanIrq;
	endsequence

	chk_timing_hold: assert property (@(posedge clk) disable iff (srst)
		(convRun || cmpEn) && !$past(srst) |=> $stable(modeReg0[5:1]))
		else $error("Timing bits changed while converter active.");
	chk_div_select: assert property (@(posedge clk) disable iff (srst)
		(state != ACTS_IDLE && ckSel == CKSEL_DIV16 && fadTick) |-> divCnt == 6'd15)
		else $error("Divide-by-16 tick at wrong count.");
	chk_conv_len: assert property (@(posedge clk) disable iff (srst)
		sampleDone |-> $past(cycCnt) == (lowVolt ? 7'd79 : 7'd63))
		else $error("Channel conversion length wrong.");
	chk_irq_delay: assert property (@(posedge clk) disable iff (srst || !cmpEn)
		(s_last_conv and (ckSel == CKSEL_DIV16)) |-> s_irq_after(17))
		else $error("Interrupt not one conversion clock after last conversion.");
	chk_no_wait: assert property (@(posedge clk) disable iff (srst)
		(state == ACTS_IDLE && cmpEn && (convRun || hwTrigger)) |=> state == ACTS_STARTT)
		else $error("Scan start was delayed.");
	chk_start_delay: assert property (@(posedge clk) disable iff (srst || !cmpEn)
		$rose(state == ACTS_DELAY) |-> $past(state) == ACTS_STARTT)
		else $error("Start time skipped.");
	chk_scan_total: assert property (@(posedge clk) disable iff (srst)
		scanIrq |-> $past(scanCnt) + 16'd1 == 16'((divTop + 1) *
			(START_TIME_CYC + START_DELAY_CYC + SCAN_CHANNELS * (convTop + 1) + IRQ_DELAY_CYC)))
		else $error("Total scan time wrong.");
	chk_irq_pulse: assert property (@(posedge clk) disable iff (srst)
		scanIrq |=> !scanIrq)
		else $error("Interrupt longer than one cycle.");

	// The start request and the hand-over from start delay to conversion are the two steps
	// where a stale divider or channel count would shift every later conversion.
	sequence s_scan_start;
		state == ACTS_IDLE && cmpEn && (convRun || hwTrigger);
	endsequence
	sequence s_enter_conv;
		state == ACTS_DELAY && fadTick;
	endsequence

	chk_start_clear: assert property (@(posedge clk) disable iff (srst)
		s_scan_start |=> divCnt == 6'h00 && chanCnt == 3'h0)
		else $error("Scan started with a stale divider or channel count.");
	chk_conv_entry: assert property (@(posedge clk) disable iff (srst || !cmpEn)
		s_enter_conv |=> state == ACTS_CONV && cycCnt == 7'h00 && chanCnt == 3'h0)
		else $error("Conversions did not begin after the start delay.");

	// The interrupt marks a complete scan, so all four channels must be counted by then.
	chk_chan_total: assert property (@(posedge clk) disable iff (srst)
		scanIrq |-> chanCnt == 3'(SCAN_CHANNELS))
		else $error("Interrupt raised before all channels were converted.");

	// A scan that ends with the hardware trigger low must leave the run bit clear, or it would restart at once.
	chk_run_clear: assert property (@(posedge clk) disable iff (srst)
		scanIrq && !$past(hwTrigger) |-> !convRun)
		else $error("Run bit still set after a completed scan.");

	// Clearing the enable is an abort: no late completion pulse may leak out of it.
	chk_abort_quiet: assert property (@(posedge clk) disable iff (srst)
		!cmpEn |=> state == ACTS_IDLE && !scanIrq && !sampleDone)
		else $error("Scan output seen after the converter was disabled.");

	// Every conversion clock pulse must come from a full divider period.
	chk_tick_source: assert property (@(posedge clk) disable iff (srst)
		convTick |-> $past(divCnt) == $past(divTop))
		else $error("Conversion clock pulse without a full divider period.");
endmodule // acts_timing_select

/* File: test/test_acts_timing_select.sv */
// Self-checking bench for the conversion timing select block.
`timescale 1ns/1ps
module test_acts_timing_select import acts_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic hwTrigger = 1'b0;
	logic rdPend = 1'b0;
	logic [31:0] r;
	wire logic [7:0] rdData;
	wire logic convTick;
	wire logic sampleDone;
	wire logic scanIrq;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int startCyc = 0;
	int nDone = 0;
	logic [7:0] expQ[$];
	int latQ[$];
	int nTick = 0;
	int tickQ[$];

	always #10 clk = ~clk;

	acts_timing_select DUT (.clk(clk), .srst(srst), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .hwTrigger(hwTrigger), .rdData(rdData),
		.convTick(convTick), .sampleDone(sampleDone), .scanIrq(scanIrq));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Strobes stay up between back-to-back accesses; a group of accesses ends with bus_idle.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		rdStb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		expQ.push_back(e);
		addr <= a;
		wrStb <= 1'b0;
		rdStb <= 1'b1;
		@(posedge clk);
	endtask

	task automatic bus_idle();
		wrStb <= 1'b0;
		rdStb <= 1'b0;
	endtask

	// The wait is cut short by the cycle ceiling if the interrupt never comes.
	task automatic scan(input int lat, input int ticks);
		latQ.push_back(lat);
		tickQ.push_back(ticks);
		@(posedge clk iff scanIrq);
	endtask

	// Latency is counted from two edges before the one that takes the start request.
	// The last conversion clock pulse arrives together with the interrupt.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rdPend <= rdStb;
		if (rdPend) begin
			check(rdData, expQ.pop_front());
		end
		if (sampleDone) begin
			nDone <= nDone + 1;
		end
		if (scanIrq) begin
			check(cyc - startCyc, latQ.pop_front());
			check(nDone, 4);
			check(nTick + 32'(convTick), tickQ.pop_front());
			nDone <= 0;
			nTick <= 0;
		end else if (convTick) begin
			nTick <= nTick + 1;
		end
		if (cyc > 30000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		r = $urandom(32'h47d6c36d);
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_MODE0, 8'h00);
		rd(OFF_MODE1, 8'h00);
		rd(4'hf, 8'h00);
		// External input and external reference, so normal mode 1 is allowed.
		wr(OFF_MODE0, 8'h09);
		startCyc = cyc;
		wr(OFF_MODE0, 8'h89);
		bus_idle();
		scan(16 * (3 + 4 * 64) + 3, 3 + 4 * 64);
		@(posedge clk);
		rd(OFF_MODE0, 8'h09);
		rd(OFF_COUNT, 8'h04);
		rd(OFF_STATUS, 8'h00);
		r = $urandom;
		wr(OFF_MODE0, {2'b00, r[5:3], 2'b11, 1'b1});
		rd(OFF_MODE0, 8'h09);
		wr(OFF_MODE0, 8'h00);
		bus_idle();
		repeat (10) @(posedge clk);
		startCyc = cyc;
		// Low-voltage mode 1 at a 1.5625 MHz conversion clock, external target and reference.
		wr(OFF_MODE0, 8'h05);
		bus_idle();
		hwTrigger <= 1'b1;
		@(posedge clk);
		hwTrigger <= 1'b0;
		scan(32 * (3 + 4 * 80) + 3, 3 + 4 * 80);
		wr(OFF_MODE0, 8'h00);
		bus_idle();
		repeat (3) @(posedge clk);
		report_and_stop();
	end
endmodule // test_acts_timing_select
